/* verilog/nst_pkg.sv */
// network time counter: shared constants, register offsets and carriers
// assumes one 250 MHz clock and a link engine on that same clock
package tmr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned BASE_RES_PS      = 2000000;  // 2.0us at code 000
  localparam int unsigned BASE_TICK_CYCLES = (BASE_RES_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DIV_WIDTH        = 16;

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL      = 4'h0;  // [2:0] prescale [6:3] cycle [7] send
  localparam logic [3:0] OFS_MASTER_ID = 4'h1;
  localparam logic [3:0] OFS_OWN_ID    = 4'h2;
  localparam logic [3:0] OFS_TIME      = 4'h3;  // live counter, read only
  localparam logic [3:0] OFS_RX_TIME   = 4'h4;  // last received value, read only
  localparam logic [3:0] OFS_STATUS    = 4'h5;  // [0] master [1] adjust pending

  localparam int unsigned CTRL_PRE_LSB  = 0;
  localparam int unsigned CTRL_CYC_LSB  = 3;
  localparam int unsigned CTRL_SEND_BIT = 7;

  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  MASTER_ID_RESET = 8'h00;
  localparam logic [7:0]  OWN_ID_RESET    = 8'h00;
  localparam logic [15:0] TIME_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // tail position of a transmit byte
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TAIL_BODY   = 2'b00,
    TAIL_SECOND = 2'b01,  // second-to-last byte: high time byte
    TAIL_LAST   = 2'b10   // last byte: low time byte
  } tail_pos_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic      load;
    tail_pos_t tail;
    logic [7:0] data;
  } tx_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tx_byte_t;

  typedef struct packed {
    logic en;
    logic tail;
  } buf_wr_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  src;
    logic [15:0] value;
  } rx_stamp_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  page;
    logic [15:0] value;
  } stamp_wr_t;

endpackage

/* verilog/tick_divider.sv */
// free-running divider that emits a one-cycle enable every period_i cycles
// assumes period_i is held stable and at least 1
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // division
  input  wire logic [WIDTH-1:0] period_i,
  output logic                  tick_o
);

  logic [WIDTH-1:0] count_reg;
  logic             tick_reg;

  // ----------------------------------------------------------------
  // count and wrap
  // ----------------------------------------------------------------
  // registered pulse so consumers see a clean one-cycle enable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end
    else if (count_reg >= period_i - WIDTH'(1))
    begin
      count_reg <= '0;
      tick_reg  <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + WIDTH'(1);
      tick_reg  <= 1'b0;
    end
  end

  assign tick_o = tick_reg;

endmodule

/* verilog/network_time_pulse_and_stamp.sv */
// network time counter with pulse output, transmit stamping, receive capture
// assumes the link engine and the register master share clk_i
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module network_time_pulse_and_stamp #(
  parameter int unsigned BASE_TICK_CYCLES = tmr_pkg::BASE_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  // register port
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [15:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic [15:0]              reg_rdata_o,
  // transmit side
  input  wire tmr_pkg::tx_req_t    tx_req_i,
  input  wire logic                tx_stamp_point_i,
  output tmr_pkg::tx_byte_t        tx_byte_o,
  // cpu writes into transmit buffer
  input  wire tmr_pkg::buf_wr_t    cpu_buf_wr_i,
  output logic                     cpu_buf_wr_en_o,
  // receive side
  input  wire tmr_pkg::rx_stamp_t  rx_stamp_i,
  input  wire logic                rx_frame_ok_i,
  input  wire logic                rx_frame_bad_i,
  output tmr_pkg::stamp_wr_t       stamp_wr_o,
  // time outputs
  output logic                     time_pulse_out_n_o,
  output logic [15:0]              network_time_value_o
);

  logic [7:0]         ctrl_reg;
  logic [7:0]         clock_master_node_reg;
  logic [7:0]         own_id_reg;
  logic [15:0]        rdata_reg;
  logic [15:0]        cnt_reg;
  logic [15:0]        cnt_next;
  logic [7:0]         stage_reg;
  logic               pulse_n_reg;
  logic [15:0]        stamp_reg;
  tmr_pkg::tx_byte_t  tx_byte_reg;
  tmr_pkg::stamp_wr_t stamp_wr_reg;
  logic               pend_reg;
  logic [7:0]         pend_src_reg;
  logic [15:0]        pend_val_reg;
  logic [15:0]        rx_time_reg;
  logic [2:0]         time_prescale_sel;
  logic [3:0]         pulse_cycle_sel;
  logic               send_mode;
  logic               is_master;
  logic               stamp_on;
  logic               base_tick;
  logic               res_tick;
  logic               adjust;
  logic [7:0]         res_mask;
  logic [15:0]        cyc_mask;

  assign time_prescale_sel = ctrl_reg[tmr_pkg::CTRL_PRE_LSB +: 3];
  assign pulse_cycle_sel   = ctrl_reg[tmr_pkg::CTRL_CYC_LSB +: 4];
  assign send_mode         = ctrl_reg[tmr_pkg::CTRL_SEND_BIT];
  assign is_master         = (own_id_reg == clock_master_node_reg);
  assign stamp_on          = send_mode | is_master;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // writes to control and id registers; read-only offsets ignore writes
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_reg              <= tmr_pkg::CTRL_RESET;
      clock_master_node_reg <= tmr_pkg::MASTER_ID_RESET;
      own_id_reg            <= tmr_pkg::OWN_ID_RESET;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        tmr_pkg::OFS_CTRL:      ctrl_reg <= reg_wdata_i[7:0];
        tmr_pkg::OFS_MASTER_ID: clock_master_node_reg <= reg_wdata_i[7:0];
        tmr_pkg::OFS_OWN_ID:    own_id_reg <= reg_wdata_i[7:0];
        default:                ;
      endcase
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_reg <= '0;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        tmr_pkg::OFS_CTRL:      rdata_reg <= {8'h00, ctrl_reg};
        tmr_pkg::OFS_MASTER_ID: rdata_reg <= {8'h00, clock_master_node_reg};
        tmr_pkg::OFS_OWN_ID:    rdata_reg <= {8'h00, own_id_reg};
        tmr_pkg::OFS_TIME:      rdata_reg <= cnt_reg;
        tmr_pkg::OFS_RX_TIME:   rdata_reg <= rx_time_reg;
        tmr_pkg::OFS_STATUS:    rdata_reg <= {14'h0000, pend_reg, is_master};
        default:                rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end

  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // resolution tick
  // ----------------------------------------------------------------
  tick_divider #(
    .WIDTH    (tmr_pkg::DIV_WIDTH)
  ) u_base_div (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .period_i (tmr_pkg::DIV_WIDTH'(BASE_TICK_CYCLES)),
    .tick_o   (base_tick)
  );

  // divide the 2.0us base by two to the prescale code
  assign res_mask = 8'((9'h001 << time_prescale_sel) - 9'h001);
  assign res_tick = base_tick && ((stage_reg & res_mask) == res_mask);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      stage_reg <= '0;
    else if (base_tick)
      stage_reg <= stage_reg + 8'h01;
  end

  // ----------------------------------------------------------------
  // time counter
  // ----------------------------------------------------------------
  // adjustment from the master outranks a tick in the same cycle
  assign adjust = rx_frame_ok_i && pend_reg && (pend_src_reg == clock_master_node_reg);

  always_comb
  begin
    cnt_next = cnt_reg;
    if (adjust)
      cnt_next = pend_val_reg;
    else if (res_tick)
      cnt_next = cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_reg <= tmr_pkg::TIME_RESET;
    else
      cnt_reg <= cnt_next;
  end

  assign network_time_value_o = cnt_reg;

  // ----------------------------------------------------------------
  // pulse output
  // ----------------------------------------------------------------
  // low while the low cycle+1 counter bits are zero: one tick per period
  assign cyc_mask = 16'((17'h00002 << pulse_cycle_sel) - 17'h00001);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pulse_n_reg <= 1'b1;
    else
      pulse_n_reg <= ((cnt_reg & cyc_mask) != 16'h0000);
  end

  assign time_pulse_out_n_o = pulse_n_reg;

  // ----------------------------------------------------------------
  // transmit stamping
  // ----------------------------------------------------------------
  // tail bytes come from the counter value sampled at the stamp point, not from the live counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      stamp_reg <= '0;
    else if (tx_stamp_point_i)
      stamp_reg <= cnt_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      tx_byte_reg <= '0;
    else
    begin
      tx_byte_reg.valid <= tx_req_i.load;
      if (stamp_on && tx_req_i.tail == tmr_pkg::TAIL_SECOND)
        tx_byte_reg.data <= stamp_reg[15:8];
      else if (stamp_on && tx_req_i.tail == tmr_pkg::TAIL_LAST)
        tx_byte_reg.data <= stamp_reg[7:0];
      else
        tx_byte_reg.data <= tx_req_i.data;
    end
  end

  assign tx_byte_o = tx_byte_reg;

  // the tail of the page is owned by the stamp while stamping is on
  assign cpu_buf_wr_en_o = cpu_buf_wr_i.en && !(cpu_buf_wr_i.tail && stamp_on);

  // ----------------------------------------------------------------
  // receive capture
  // ----------------------------------------------------------------
  // store at once into the source's page; adjust only after frame checks
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      stamp_wr_reg <= '0;
    else
    begin
      stamp_wr_reg.en    <= rx_stamp_i.valid;
      stamp_wr_reg.page  <= rx_stamp_i.src;
      stamp_wr_reg.value <= rx_stamp_i.value;
    end
  end

  assign stamp_wr_o = stamp_wr_reg;

  // a new stamp arriving with the verdict of the old frame wins
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pend_reg     <= 1'b0;
      pend_src_reg <= '0;
      pend_val_reg <= '0;
      rx_time_reg  <= '0;
    end
    else if (rx_stamp_i.valid)
    begin
      pend_reg     <= 1'b1;
      pend_src_reg <= rx_stamp_i.src;
      pend_val_reg <= rx_stamp_i.value;
      rx_time_reg  <= rx_stamp_i.value;
    end
    else if (rx_frame_ok_i || rx_frame_bad_i)
      pend_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a stamp, then one quiet cycle in which the value waits for its verdict
  sequence s_rx_pending;
    rx_stamp_i.valid ##1 (pend_reg && !rx_frame_ok_i && !rx_frame_bad_i);
  endsequence

  // good verdict for a value that came from the clock master's node
  sequence s_rx_confirm;
    rx_frame_ok_i && pend_reg && (pend_src_reg == clock_master_node_reg);
  endsequence

  a_tick_on_base: assert property (res_tick |-> base_tick)
    else $error("resolution tick without base tick");
  a_count_step: assert property (!adjust && res_tick |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("counter did not advance on tick");
  a_count_hold: assert property (!adjust && !res_tick |=> $stable(cnt_reg))
    else $error("counter moved without tick or adjust");
  // the registered pulse pairs the old count with the old mask
  a_pulse_low: assert property (!time_pulse_out_n_o
    |-> ($past(cnt_reg) & $past(cyc_mask)) == 16'h0000)
    else $error("pulse low outside selected cycle");
  a_tail_drop: assert property (cpu_buf_wr_i.tail && stamp_on |-> !cpu_buf_wr_en_o)
    else $error("tail write passed while stamping");
  a_tail_high: assert property (stamp_on && tx_req_i.load
    && tx_req_i.tail == tmr_pkg::TAIL_SECOND
    |=> tx_byte_o.valid && tx_byte_o.data == $past(stamp_reg[15:8]))
    else $error("high time byte not sent");
  a_master_stamp: assert property (is_master && tx_req_i.load
    && tx_req_i.tail == tmr_pkg::TAIL_LAST
    |=> tx_byte_o.data == $past(stamp_reg[7:0]))
    else $error("master did not append time");
  a_stamp_sample: assert property (tx_stamp_point_i |=> stamp_reg == $past(cnt_reg))
    else $error("stamp not sampled");
  a_rx_store: assert property (rx_stamp_i.valid |=> stamp_wr_o.en
    && stamp_wr_o.page == $past(rx_stamp_i.src) && stamp_wr_o.value == $past(rx_stamp_i.value))
    else $error("received time not stored");
  a_master_adjust: assert property (s_rx_pending ##1 s_rx_confirm
    |=> cnt_reg == $past(pend_val_reg))
    else $error("master time not adopted");
  a_bad_discard: assert property (rx_frame_bad_i && !rx_stamp_i.valid |=> !pend_reg)
    else $error("rejected frame left a value pending");

endmodule

/* sim/link_partner.sv */
// link engine stand-in: feeds transmit bytes and received time values
// assumes the time block shares clk_i; drives change just after a rising edge
`timescale 1ns/1ps
module link_partner (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // time block side
  input  wire logic [15:0]   time_i,
  output tmr_pkg::tx_req_t   tx_req_o,
  output logic               stamp_point_o,
  output tmr_pkg::rx_stamp_t rx_stamp_o,
  output logic               frame_ok_o,
  output logic               frame_bad_o
);
  // ----
  // idle levels at time zero
  // ----
  initial
  begin
    tx_req_o = '0;
    stamp_point_o = 1'b0;
    rx_stamp_o = '0;
    frame_ok_o = 1'b0;
    frame_bad_o = 1'b0;
  end

  // ----
  // transmit: one body byte, the sample point, then the two tail bytes
  // ----
  // idle data is inverted so a stale byte never passes for a good one
  task automatic send_tail(input logic [7:0] hi_b, input logic [7:0] lo_b,
                           input int gap, output logic [15:0] seen);
    tx_req_o <= '{1'b1, tmr_pkg::TAIL_BODY, 8'h5a};
    @(posedge clk_i);
    tx_req_o <= '{1'b0, tmr_pkg::TAIL_BODY, 8'ha5};
    stamp_point_o <= 1'b1;
    @(posedge clk_i);
    seen = time_i;
    stamp_point_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
    tx_req_o <= '{1'b1, tmr_pkg::TAIL_SECOND, hi_b};
    @(posedge clk_i);
    tx_req_o <= '{1'b1, tmr_pkg::TAIL_LAST, lo_b};
    @(posedge clk_i);
    tx_req_o <= '{1'b0, tmr_pkg::TAIL_BODY, ~lo_b};
    @(posedge clk_i);
  endtask

  // ----
  // receive: time value first, frame verdict one idle cycle later
  // ----
  task automatic recv(input logic [7:0] src, input logic [15:0] val, input logic good);
    rx_stamp_o <= '{1'b1, src, val};
    @(posedge clk_i);
    rx_stamp_o <= '{1'b0, ~src, ~val};
    @(posedge clk_i);
    frame_ok_o <= good;
    frame_bad_o <= !good;
    @(posedge clk_i);
    frame_ok_o <= 1'b0;
    frame_bad_o <= 1'b0;
  endtask
endmodule

/* sim/network_time_pulse_and_stamp_tb.sv */
// self-checking bench for the network time counter
// assumes the link partner model and a short base tick for quick periods
`timescale 1ns/1ps
module network_time_pulse_and_stamp_tb;
  localparam int unsigned BASE = 4; // short base tick keeps periods small

  logic               clk_i;
  logic               reset_i;
  logic [3:0]         reg_addr_i;
  logic [15:0]        reg_wdata_i;
  logic               reg_wr_i;
  logic               reg_rd_i;
  logic [15:0]        reg_rdata_o;
  tmr_pkg::tx_req_t   tx_req;
  logic               stamp_pt;
  tmr_pkg::tx_byte_t  tx_byte;
  tmr_pkg::buf_wr_t   cpu_wr;
  logic               cpu_wr_en;
  tmr_pkg::rx_stamp_t rx_stamp;
  logic               frame_ok;
  logic               frame_bad;
  tmr_pkg::stamp_wr_t stamp_wr;
  logic               pulse_n;
  logic [15:0]        time_val;
  int                 errors;
  int                 comparisons;
  logic [7:0]         tx_seen[$];
  tmr_pkg::stamp_wr_t stamp_seen;

  network_time_pulse_and_stamp #(.BASE_TICK_CYCLES(BASE)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_req_i(tx_req), .tx_stamp_point_i(stamp_pt),
    .tx_byte_o(tx_byte), .cpu_buf_wr_i(cpu_wr), .cpu_buf_wr_en_o(cpu_wr_en),
    .rx_stamp_i(rx_stamp), .rx_frame_ok_i(frame_ok), .rx_frame_bad_i(frame_bad),
    .stamp_wr_o(stamp_wr), .time_pulse_out_n_o(pulse_n), .network_time_value_o(time_val));

  link_partner lp (
    .clk_i(clk_i), .reset_i(reset_i), .time_i(time_val), .tx_req_o(tx_req),
    .stamp_point_o(stamp_pt), .rx_stamp_o(rx_stamp), .frame_ok_o(frame_ok),
    .frame_bad_o(frame_bad));

  // ----
  // clock, watchdog and output monitor
  // ----
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // pulse tests dominate; at most about 13k cycles expected
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  always @(posedge clk_i)
  begin
    if (tx_byte.valid === 1'b1) tx_seen.push_back(tx_byte.data);
    if (stamp_wr.en === 1'b1) stamp_seen <= stamp_wr;
  end

  // ----
  // shared tasks
  // ----
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // tasks enter and leave just after a rising edge
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    d = reg_rdata_o;
  endtask

  // bounded wait for a pulse level, counting edges
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (pulse_n !== lvl && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic pulse_case(input int pre, input int cyc);
    int lo;
    int hi;
    logic [15:0] t0;
    reg_write(tmr_pkg::OFS_CTRL, 16'((pre << tmr_pkg::CTRL_PRE_LSB) |
                                     (cyc << tmr_pkg::CTRL_CYC_LSB)));
    repeat (2)
    begin
      wait_lvl(1'b1, lo);
      wait_lvl(1'b0, lo);
    end
    t0 = time_val;
    wait_lvl(1'b1, lo);
    wait_lvl(1'b0, hi);
    check("low width", 16'(lo), 16'(BASE << pre));
    check("period", 16'(lo + hi), 16'((BASE << pre) << (cyc + 1)));
    check("ticks per period", time_val - t0, 16'(1 << (cyc + 1)));
  endtask

  task automatic tx_case(input logic [15:0] own, input logic [15:0] mst,
                         input logic [15:0] ctrl, input logic stamped);
    logic [15:0] s;
    reg_write(tmr_pkg::OFS_OWN_ID, own);
    reg_write(tmr_pkg::OFS_MASTER_ID, mst);
    reg_write(tmr_pkg::OFS_CTRL, ctrl);
    reg_read(tmr_pkg::OFS_STATUS, s);
    check("master flag", s & 16'h0001, 16'(own == mst));
    cpu_wr <= '{1'b1, 1'b1};
    @(posedge clk_i);
    check("tail write enable", 16'(cpu_wr_en), 16'(!stamped));
    cpu_wr <= '{1'b1, 1'b0};
    @(posedge clk_i);
    check("body write enable", 16'(cpu_wr_en), 16'h0001);
    cpu_wr <= '0;
    tx_seen.delete();
    lp.send_tail(8'hc3, 8'h3c, 5, s);
    @(posedge clk_i);
    check("byte count", 16'(tx_seen.size()), 16'h0003);
    check("body byte", 16'(tx_seen[0]), 16'h005a);
    check("high tail", 16'(tx_seen[1]), stamped ? 16'(s[15:8]) : 16'h00c3);
    check("low tail", 16'(tx_seen[2]), stamped ? 16'(s[7:0]) : 16'h003c);
  endtask

  task automatic rx_case(input logic [7:0] src, input logic [15:0] v, input logic good,
                         input logic adj);
    stamp_seen = '0;
    lp.recv(src, v, good);
    #1;
    check("time adjusted", 16'(time_val === v), 16'(adj));
    @(posedge clk_i);
    check("stamp page", 16'(stamp_seen.page), 16'(src));
    check("stamp value", stamp_seen.value, v);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    logic [15:0] r;
    reset_i = 1'b1;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    cpu_wr = '0;
    errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    reg_read(tmr_pkg::OFS_CTRL, r);
    check("ctrl reset", r, 16'(tmr_pkg::CTRL_RESET));
    reg_read(tmr_pkg::OFS_STATUS, r);
    check("status reset", r, 16'h0001);
    reg_write(tmr_pkg::OFS_RX_TIME, 16'hffff);
    reg_read(tmr_pkg::OFS_RX_TIME, r);
    check("read only", r, 16'h0000);
    reg_read(4'hf, r);
    check("unmapped", r, 16'h0000);
    $display("test registers done");
    for (int p = 0; p < 8; p++) pulse_case(p, (7 - p) & 3);
    $display("test pulse done");
    tx_case(16'h0000, 16'h0000, 16'h0000, 1'b1);
    tx_case(16'h0001, 16'h0002, 16'h0000, 1'b0);
    tx_case(16'h0001, 16'h0002, 16'(1 << tmr_pkg::CTRL_SEND_BIT), 1'b1);
    $display("test transmit done");
    reg_write(tmr_pkg::OFS_MASTER_ID, 16'h0005);
    rx_case(8'h03, 16'h1234, 1'b1, 1'b0);
    rx_case(8'h05, 16'h4321, 1'b0, 1'b0);
    rx_case(8'h05, 16'h4321, 1'b1, 1'b1);
    $display("test receive done");
    report_and_stop();
  end
endmodule
